// ---- design/fcm_pkg.sv ----
// constants and types for the floating-point context and mode control block
package fcm_pkg;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] FCM_CTRL_OFF = 8'h00;
  localparam logic [7:0] FCM_MODE_OFF = 8'h04;
  localparam logic [7:0] FCM_STAT_OFF = 8'h08;
  localparam logic [7:0] FCM_MASK_OFF = 8'h0C;
  localparam logic [7:0] FCM_CTX_OFF = 8'h10;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int FCM_EN_BIT = 0;
  localparam int FCM_CTX_LSB = 1;
  localparam int FCM_FTZ_BIT = 0;
  localparam int FCM_HALF_BIT = 1;
  localparam int FCM_NAN_BIT = 2;
  localparam int FCM_RND_LSB = 3;
  localparam int FCM_FAULT_BIT = 6;
  localparam int FCM_NSRC = 7;
  // ---------------------------------------------------------------
  // reset values and encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] FCM_RND_NEAREST = 2'h0;
  localparam logic [1:0] FCM_RND_UP = 2'h1;
  localparam logic [1:0] FCM_RND_DOWN = 2'h2;
  localparam logic [1:0] FCM_RND_ZERO = 2'h3;
  localparam logic FCM_FTZ_RST = 1'b0;
  localparam logic FCM_HALF_RST = 1'b0;
  localparam logic FCM_NAN_RST = 1'b0;
  localparam logic FCM_EN_RST = 1'b0;
  localparam logic [6:0] FCM_MASK_RST = 7'h00;
  // frame sizes in words
  localparam logic [4:0] FCM_FRAME_INT = 5'h08;
  localparam logic [4:0] FCM_FRAME_FP = 5'h1A;
  // nesting depth of tracked exception frames
  localparam int FCM_DEPTH = 8;
  localparam logic [3:0] FCM_DEPTH_MAX = 4'h8;
  typedef enum logic [1:0] {FCM_CTX_NONE, FCM_CTX_ALWAYS, FCM_CTX_LAZY} fcm_ctx_t;
  localparam fcm_ctx_t FCM_CTX_RST = FCM_CTX_LAZY;
endpackage

// ---- design/fcm_top.sv ----
// floating-point enable gate, context stacking control, exception interrupts and modes
// Functional notes
// RQ1: unit disabled after reset; software enables before any instruction runs.
// RQ2: instruction issued while disabled is dropped and raises no-coprocessor usage fault.
// RQ3: clearing enable makes every later instruction fault instead of executing.
// RQ4: stacking off gives integer-only frame like a core without the unit.
// RQ5: always-save mode writes floating-point context on every interrupt entry; code skips the save for an entry with 8 frames already tracked.
// RQ6: lazy mode is default; entry reserves space, writes only integer state.
// RQ7: lazy mode saves context before first instruction inside a handler executes; an issue in the cycle of an entry or return executes with no save.
// RQ8: lazy mode restores on return only if context was written.
// RQ9: six arithmetic exceptions detected, each may raise the interrupt.
// RQ10: each exception interrupt source has its own enable.
// RQ11: flush-to-zero off after reset; a bit selects off or on.
// RQ12: flush-to-zero on treats tiny operands and results as zero.
// RQ13: half format select chooses IEEE or wide layout, IEEE at reset.
// RQ14: wide half layout uses extra range, no infinity or NaN codes.
// RQ15: software sets mode bits before the first instruction, else defaults.
// RQ16: NaN mode selects pass-through (default) or canonical default NaN.
// RQ17: rounding field selects nearest (default), up, down or toward zero.
// RQ18: context stacking grows frame from 8 words to 26 words.
// RQ19: pending-lazy-save flag per active frame, set at entry, cleared when saved; code keeps flags for at most 8 frames, deeper entries get none.
`timescale 1ns/1ps
module fcm_top
  import fcm_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_we,
  input wire logic i_re,
  input wire logic i_fp_issue,
  input wire logic i_exc_entry,
  input wire logic i_exc_return,
  input wire logic [5:0] i_fp_exc,
  output logic [31:0] o_rdata,
  output logic o_fp_exec,
  output logic o_no_coprocessor_usage_fault,
  output logic o_ctx_save,
  output logic o_ctx_restore,
  output logic [4:0] o_frame_words,
  output logic o_flush_zero_on,
  output logic o_half_format_wide_range,
  output logic o_nan_return_canonical,
  output logic [1:0] o_round_mode,
  output logic o_irq
);
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic en_r;
  fcm_ctx_t ctx_r;
  logic [6:0] stat_r;
  logic [6:0] mask_r;
  logic [3:0] depth_r;
  logic [FCM_DEPTH-1:0] pend_r;
  logic [FCM_DEPTH-1:0] saved_r;
  logic hold_r;
  logic [3:0] top_idx;
  logic cur_pend;
  logic wr_ctrl;
  logic wr_mode;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  assign wr_ctrl = i_we && hit(i_addr, FCM_CTRL_OFF);
  assign wr_mode = i_we && hit(i_addr, FCM_MODE_OFF);
  assign top_idx = depth_r - 4'h1;
  assign cur_pend = (depth_r != 4'h0) && pend_r[top_idx[2:0]];

  // ---------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------
  // RQ1 disabled at reset
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      en_r <= FCM_EN_RST;
      ctx_r <= FCM_CTX_RST;
    end else if (wr_ctrl) begin
      en_r <= i_wdata[FCM_EN_BIT];
      // code 3 is not a mode; such a write keeps the old mode
      if (i_wdata[FCM_CTX_LSB+1:FCM_CTX_LSB] != 2'h3) begin
        ctx_r <= fcm_ctx_t'(i_wdata[FCM_CTX_LSB+1:FCM_CTX_LSB]);
      end
    end
  end

  // ---------------------------------------------------------------
  // mode register, driven straight to the datapath
  // ---------------------------------------------------------------
  // RQ11 flush-to-zero bit
  // RQ12 RQ13 RQ14 RQ16 RQ17 mode selects
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_flush_zero_on <= FCM_FTZ_RST;
      o_half_format_wide_range <= FCM_HALF_RST;
      o_nan_return_canonical <= FCM_NAN_RST;
      o_round_mode <= FCM_RND_NEAREST;
    end else if (wr_mode) begin
      o_flush_zero_on <= i_wdata[FCM_FTZ_BIT];
      o_half_format_wide_range <= i_wdata[FCM_HALF_BIT];
      o_nan_return_canonical <= i_wdata[FCM_NAN_BIT];
      o_round_mode <= i_wdata[FCM_RND_LSB+1:FCM_RND_LSB];
    end
  end

  // ---------------------------------------------------------------
  // instruction gate and lazy save sequencing
  // ---------------------------------------------------------------
  // RQ2 RQ3 fault when disabled
  // RQ7 save then execute one cycle later
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_fp_exec <= 1'b0;
      o_no_coprocessor_usage_fault <= 1'b0;
      hold_r <= 1'b0;
    end else begin
      o_no_coprocessor_usage_fault <= i_fp_issue && !en_r;
      hold_r <= i_fp_issue && en_r && cur_pend && ctx_r == FCM_CTX_LAZY;
      o_fp_exec <= hold_r || (i_fp_issue && en_r && !(cur_pend && ctx_r == FCM_CTX_LAZY));
    end
  end

  // ---------------------------------------------------------------
  // exception frame tracking
  // ---------------------------------------------------------------
  // frames past the tracked depth are not recorded; deeper nesting is a limitation
  // RQ19 pending flag per frame
  // RQ5 RQ6 RQ8 entry and return handling
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      depth_r <= 4'h0;
      pend_r <= '0;
      saved_r <= '0;
      o_ctx_save <= 1'b0;
      o_ctx_restore <= 1'b0;
    end else begin
      o_ctx_save <= 1'b0;
      o_ctx_restore <= 1'b0;
      if (i_exc_entry && depth_r != FCM_DEPTH_MAX) begin
        depth_r <= depth_r + 4'h1;
        pend_r[depth_r[2:0]] <= ctx_r == FCM_CTX_LAZY;
        saved_r[depth_r[2:0]] <= ctx_r == FCM_CTX_ALWAYS;
        o_ctx_save <= ctx_r == FCM_CTX_ALWAYS;
      end else if (i_exc_return && depth_r != 4'h0) begin
        depth_r <= depth_r - 4'h1;
        pend_r[top_idx[2:0]] <= 1'b0;
        saved_r[top_idx[2:0]] <= 1'b0;
        o_ctx_restore <= saved_r[top_idx[2:0]];
      end else if (i_fp_issue && en_r && cur_pend && ctx_r == FCM_CTX_LAZY) begin
        pend_r[top_idx[2:0]] <= 1'b0;
        saved_r[top_idx[2:0]] <= 1'b1;
        o_ctx_save <= 1'b1;
      end
    end
  end

  // RQ4 RQ18 frame size follows stacking mode
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_frame_words <= FCM_FRAME_FP;
    end else if (i_exc_entry) begin
      o_frame_words <= (ctx_r == FCM_CTX_NONE) ? FCM_FRAME_INT : FCM_FRAME_FP;
    end
  end

  // ---------------------------------------------------------------
  // interrupt status and mask
  // ---------------------------------------------------------------
  logic [6:0] ev;
  assign ev = {o_no_coprocessor_usage_fault, i_fp_exc};

  // RQ9 sticky exception flags; set wins over clear
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      stat_r <= 7'h00;
    end else begin
      stat_r <= (stat_r & ~((i_we && hit(i_addr, FCM_STAT_OFF)) ? i_wdata[6:0] : 7'h00)) | ev;
    end
  end

  // RQ10 per-source enable
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mask_r <= FCM_MASK_RST;
      o_irq <= 1'b0;
    end else begin
      if (i_we && hit(i_addr, FCM_MASK_OFF)) begin
        mask_r <= i_wdata[6:0];
      end
      o_irq <= |(stat_r & mask_r);
    end
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rdata <= 32'h0000_0000;
    end else if (i_re) begin
      unique case (i_addr)
        FCM_CTRL_OFF: o_rdata <= {29'h0000_0000, ctx_r, en_r};
        FCM_MODE_OFF: o_rdata <= {27'h0000_0000, o_round_mode, o_nan_return_canonical,
                                  o_half_format_wide_range, o_flush_zero_on};
        FCM_STAT_OFF: o_rdata <= {25'h0000_0000, stat_r};
        FCM_MASK_OFF: o_rdata <= {25'h0000_0000, mask_r};
        FCM_CTX_OFF: o_rdata <= {8'h00, saved_r, 4'h0, pend_r, depth_r};
        default: o_rdata <= 32'h0000_0000;
      endcase
    end else begin
      o_rdata <= 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_reset_off;
    @(posedge i_sys_clk) $rose(i_reset_n) |-> !en_r;
  endproperty
  a_reset_off: assert property (p_reset_off) else $error("unit enabled at reset"); // RQ1

  property p_fault;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      (i_fp_issue && !en_r) |=> (o_no_coprocessor_usage_fault && !o_fp_exec);
  endproperty
  a_fault: assert property (p_fault) else $error("disabled issue did not fault"); // RQ2

  property p_clear_blocks;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      (wr_ctrl && !i_wdata[FCM_EN_BIT]) ##1 (!wr_ctrl)[*1] ##1 i_fp_issue
      |=> (o_no_coprocessor_usage_fault && !o_fp_exec);
  endproperty
  a_clear_blocks: assert property (p_clear_blocks) else $error("issue after disable ran"); // RQ3

  property p_none_frame;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      (i_exc_entry && ctx_r == FCM_CTX_NONE) |=> (o_frame_words == FCM_FRAME_INT && !o_ctx_save);
  endproperty
  a_none_frame: assert property (p_none_frame) else $error("no-stack frame wrong"); // RQ4

  property p_always_save;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      (i_exc_entry && depth_r != FCM_DEPTH_MAX && ctx_r == FCM_CTX_ALWAYS) |=> o_ctx_save;
  endproperty
  a_always_save: assert property (p_always_save) else $error("always mode did not save"); // RQ5

  property p_lazy_entry;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      (i_exc_entry && ctx_r == FCM_CTX_LAZY) |=> (!o_ctx_save && o_frame_words == FCM_FRAME_FP);
  endproperty
  a_lazy_entry: assert property (p_lazy_entry) else $error("lazy entry wrote context"); // RQ6

  property p_lazy_first;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      (i_fp_issue && en_r && cur_pend && ctx_r == FCM_CTX_LAZY && !i_exc_entry && !i_exc_return)
      |=> (o_ctx_save && !o_fp_exec) ##1 o_fp_exec;
  endproperty
  a_lazy_first: assert property (p_lazy_first) else $error("lazy save not before execute"); // RQ7

  property p_restore;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      (i_exc_return && !i_exc_entry && depth_r != 4'h0) |=> (o_ctx_restore == $past(saved_r[top_idx[2:0]]));
  endproperty
  a_restore: assert property (p_restore) else $error("restore does not match saved"); // RQ8

  property p_irq;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      (|(i_fp_exc & mask_r[5:0]) && !i_we) |-> ##2 o_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("enabled exception gave no interrupt"); // RQ9 RQ10

  property p_mode_hold;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      !wr_mode |=> $stable(o_round_mode) && $stable(o_flush_zero_on);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode changed without write"); // RQ11 RQ17

  property p_fmt_hold;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      !wr_mode |=> $stable(o_half_format_wide_range) && $stable(o_nan_return_canonical);
  endproperty
  a_fmt_hold: assert property (p_fmt_hold) else $error("format or nan mode changed without write"); // RQ13 RQ16

  property p_mode_write;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      wr_mode |=> (o_flush_zero_on == $past(i_wdata[FCM_FTZ_BIT])) && (o_round_mode == $past(i_wdata[4:3]));
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("mode write did not land"); // RQ11 RQ17

  // fault must reach status even when software clears it in the same cycle
  property p_fault_status;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      o_no_coprocessor_usage_fault |=> stat_r[FCM_FAULT_BIT];
  endproperty
  a_fault_status: assert property (p_fault_status) else $error("fault not recorded in status"); // RQ2

  property p_exec_gate;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      (!en_r && !hold_r) |=> !o_fp_exec;
  endproperty
  a_exec_gate: assert property (p_exec_gate) else $error("instruction ran while disabled"); // RQ1 RQ3

  property p_lazy_clears;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      (i_fp_issue && en_r && cur_pend && ctx_r == FCM_CTX_LAZY && !i_exc_entry && !i_exc_return) |=> !cur_pend;
  endproperty
  a_lazy_clears: assert property (p_lazy_clears) else $error("pending flag kept after save"); // RQ19

  // a frame still waiting for its lazy save was never written, so nothing comes back
  property p_no_restore_pend;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      (i_exc_return && !i_exc_entry && cur_pend) |=> !o_ctx_restore;
  endproperty
  a_no_restore_pend: assert property (p_no_restore_pend) else $error("restore of unsaved context"); // RQ8

  property p_depth_cap;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      depth_r <= FCM_DEPTH_MAX;
  endproperty
  a_depth_cap: assert property (p_depth_cap) else $error("frame depth past limit"); // RQ19

  property p_frame_size;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      (o_frame_words == FCM_FRAME_INT) || (o_frame_words == FCM_FRAME_FP);
  endproperty
  a_frame_size: assert property (p_frame_size) else $error("frame size not a legal value"); // RQ4 RQ18

  property p_stat_sticky;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      !(i_we && hit(i_addr, FCM_STAT_OFF)) |=> ((stat_r & $past(stat_r)) == $past(stat_r));
  endproperty
  a_stat_sticky: assert property (p_stat_sticky) else $error("status bit lost without clear"); // RQ9

  property p_irq_quiet;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      ((stat_r & mask_r) == 7'h00) |=> !o_irq;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("interrupt from masked source"); // RQ10

  c_fault: cover property (@(posedge i_sys_clk) o_no_coprocessor_usage_fault);
  c_lazy_save: cover property (@(posedge i_sys_clk) hold_r ##1 o_fp_exec);
  c_restore: cover property (@(posedge i_sys_clk) o_ctx_restore);
  c_irq: cover property (@(posedge i_sys_clk) o_irq);
  c_always_save: cover property (@(posedge i_sys_clk) (i_exc_entry && ctx_r == FCM_CTX_ALWAYS) ##1 o_ctx_save);
endmodule

// ---- tb/fcm_core_model.sv ----
// core-side model that sends exception entry, return and instruction issue
`timescale 1ns/1ps
module fcm_core_model (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_req_entry,
  input wire logic i_req_return,
  input wire logic i_req_issue,
  output logic o_exc_entry,
  output logic o_exc_return,
  output logic o_fp_issue
);
  logic [3:0] depth_r;
  logic issued_r;
  // entry wins over return; no return without an open frame
  assign o_exc_entry = i_req_entry && (depth_r < 4'h8);
  assign o_exc_return = i_req_return && !i_req_entry && (depth_r != 4'h0);
  // one idle cycle after an issue, since a lazy save may be in flight
  assign o_fp_issue = i_req_issue && !issued_r;
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      depth_r <= 4'h0;
      issued_r <= 1'b0;
    end else begin
      depth_r <= depth_r + 4'(o_exc_entry) - 4'(o_exc_return);
      issued_r <= o_fp_issue;
    end
  end
endmodule

// ---- tb/tb_fpu_context_and_mode_control.sv ----
// self-checking bench for the fp context and mode control block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin failures++; \
  $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module tb_fpu_context_and_mode_control;
  import fcm_pkg::*;
  logic i_sys_clk = 1'b0, i_reset_n = 1'b0, i_we = 1'b0, i_re = 1'b0, m;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0000_0000, rv, rdata;
  logic [5:0] i_fp_exc = 6'h00;
  logic [2:0] req = 3'h0;
  logic entry, ret, issue, fp_exec, fault, save, restore, flush, half, nan, irq;
  logic [4:0] frame, v;
  logic [1:0] rnd, ctx;
  int failures = 0, n_compared = 0, cyc = 0, t_iss = 0, t_sav = 0, t_exe = 0;
  int n[4] = '{0, 0, 0, 0};
  int snap[4];
  always #2.5 i_sys_clk = ~i_sys_clk;
  fcm_core_model core_model (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_req_entry(req[0]),
    .i_req_return(req[1]), .i_req_issue(req[2]), .o_exc_entry(entry), .o_exc_return(ret), .o_fp_issue(issue));
  fcm_top DUT (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_we(i_we),
    .i_re(i_re), .i_fp_issue(issue), .i_exc_entry(entry), .i_exc_return(ret), .i_fp_exc(i_fp_exc),
    .o_rdata(rdata), .o_fp_exec(fp_exec), .o_no_coprocessor_usage_fault(fault), .o_ctx_save(save),
    .o_ctx_restore(restore), .o_frame_words(frame), .o_flush_zero_on(flush), .o_half_format_wide_range(half),
    .o_nan_return_canonical(nan), .o_round_mode(rnd), .o_irq(irq));
  // ---------------------------------------------------------------
  // pulse stamps and counts, taken from what the design and the core model drive
  // ---------------------------------------------------------------
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (issue === 1'b1) t_iss <= cyc;
    if (save === 1'b1) t_sav <= cyc;
    if (fp_exec === 1'b1) t_exe <= cyc;
    n[0] <= n[0] + int'(save === 1'b1);
    n[1] <= n[1] + int'(fp_exec === 1'b1);
    n[2] <= n[2] + int'(fault === 1'b1);
    n[3] <= n[3] + int'(restore === 1'b1);
  end
  // ---------------------------------------------------------------
  // bus, core and check tasks
  // ---------------------------------------------------------------
  function automatic logic [31:0] ctrl_v(input logic [1:0] c, input logic e);
    return {29'h0000_0000, c, e};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_we <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge i_sys_clk);
    i_re <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_re <= 1'b0;
    @(negedge i_sys_clk);
    rv = rdata;
  endtask
  // k: 0 entry, 1 return, 2 issue; waits long enough for every answer
  task automatic core(input int k);
    snap = n;
    @(posedge i_sys_clk);
    req[k] <= 1'b1;
    @(posedge i_sys_clk);
    req[k] <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
  endtask
  task automatic pulses(input int s, input int e, input int f, input int r);
    `CHK("save pulses", s, n[0] - snap[0])
    `CHK("exec pulses", e, n[1] - snap[1])
    `CHK("fault pulses", f, n[2] - snap[2])
    `CHK("restore pulses", r, n[3] - snap[3])
  endtask
  task automatic report_and_stop();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(19));
    repeat (12) @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
    rd(FCM_CTRL_OFF);
    `CHK("ctrl reset", ctrl_v(FCM_CTX_RST, FCM_EN_RST), rv)
    `CHK("frame reset", FCM_FRAME_FP, frame)
    rd(FCM_MODE_OFF);
    `CHK("mode reset", 32'h0000_0000, rv)
    rd(FCM_MASK_OFF);
    `CHK("mask reset", 32'h0000_0000, rv)
    rd(8'h14);
    `CHK("unmapped read", 32'h0000_0000, rv)
    for (int i = 0; i < 8; i++) begin
      v = {i[1:0], 3'($urandom)};
      wr(FCM_MODE_OFF, 32'(v));
      rd(FCM_MODE_OFF);
      `CHK("mode readback", 32'(v), rv)
      `CHK("flush zero", v[FCM_FTZ_BIT], flush)
      `CHK("half format", v[FCM_HALF_BIT], half)
      `CHK("nan mode", v[FCM_NAN_BIT], nan)
      `CHK("round mode", v[4:3], rnd)
    end
    // modes settled before the first instruction
    wr(FCM_MODE_OFF, 32'h0000_0000);
    core(2);
    pulses(0, 0, 1, 0);
    rd(FCM_STAT_OFF);
    `CHK("fault status", 1'b1, rv[FCM_FAULT_BIT])
    for (int c = 0; c < 3; c++) begin
      ctx = 2'(c);
      wr(FCM_CTRL_OFF, ctrl_v(ctx, 1'b1));
      core(0);
      `CHK("frame words", (ctx == FCM_CTX_NONE) ? FCM_FRAME_INT : FCM_FRAME_FP, frame)
      pulses(ctx == FCM_CTX_ALWAYS, 0, 0, 0);
      core(2);
      pulses(ctx == FCM_CTX_LAZY, 1, 0, 0);
      `CHK("exec delay", (ctx == FCM_CTX_LAZY) ? 2 : 1, t_exe - t_iss)
      if (ctx == FCM_CTX_LAZY) `CHK("save delay", 1, t_sav - t_iss)
      core(2);
      pulses(0, 1, 0, 0);
      core(1);
      pulses(0, 0, 0, ctx != FCM_CTX_NONE);
    end
    core(0);
    core(1);
    pulses(0, 0, 0, 0);
    wr(FCM_CTRL_OFF, ctrl_v(FCM_CTX_LAZY, 1'b0));
    core(2);
    pulses(0, 0, 1, 0);
    // code 3 is not a context mode, only the enable lands
    wr(FCM_CTRL_OFF, ctrl_v(2'h3, 1'b1));
    rd(FCM_CTRL_OFF);
    `CHK("ctrl code 3", ctrl_v(FCM_CTX_LAZY, 1'b1), rv)
    wr(FCM_STAT_OFF, 32'h0000_007F);
    for (int b = 0; b < 6; b++) begin
      m = (b == 0) ? 1'b1 : 1'($urandom);
      wr(FCM_MASK_OFF, 32'(m) << b);
      @(posedge i_sys_clk);
      i_fp_exc <= 6'(1 << b);
      @(posedge i_sys_clk);
      i_fp_exc <= 6'h00;
      repeat (3) @(posedge i_sys_clk);
      @(negedge i_sys_clk);
      `CHK("irq raised", m, irq)
      rd(FCM_STAT_OFF);
      `CHK("status bit", 1'b1, rv[b])
      wr(FCM_STAT_OFF, 32'h0000_0001 << b);
      repeat (3) @(posedge i_sys_clk);
      @(negedge i_sys_clk);
      `CHK("irq cleared", 1'b0, irq)
    end
    report_and_stop();
  end
  // the scenarios need well under 2000 cycles
  initial begin
    #100000;
    failures++;
    report_and_stop();
  end
endmodule
